// ==== compat_pkg.sv ====
// Shared constants and carrier types for the legacy compatibility mode controller
package compat_pkg;

	// Register offsets (byte addresses on the AHB-Lite slave)
	localparam logic [7:0] ADDR_MODE_STATUS = 8'h00;
	localparam logic [7:0] ADDR_DATA_ACCESS = 8'h04;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'h08;
	localparam logic [7:0] ADDR_OSC_TRIM = 8'h0c;
	localparam logic [7:0] ADDR_WDT_CTRL = 8'h10;
	localparam logic [7:0] ADDR_EXTINT_SENSE = 8'h14;
	localparam logic [7:0] ADDR_XMEM_CTRL = 8'h18;
	localparam logic [7:0] ADDR_PORT_DIR = 8'h1c;

	// Extended I/O window bounds in data space
	localparam logic [15:0] EXT_IO_LO = 16'h0060;
	localparam logic [15:0] EXT_IO_HI = 16'h00ff;

	// Mode status bit positions
	localparam int MS_COMPAT_BIT = 0;
	localparam int MS_VIOL_BIT = 1;

	// Data access probe register fields
	localparam int DA_ADDR_LSB = 0;
	localparam int DA_IO_INSN_BIT = 16;

	// Reset cause flag positions
	localparam int RC_POR_BIT = 0;
	localparam int RC_EXT_BIT = 1;
	localparam int RC_BOD_BIT = 2;
	localparam int RC_WDT_BIT = 3;
	localparam int RC_JTAG_BIT = 4;
	localparam logic [7:0] RC_LEGACY_MASK = 8'h03;
	localparam logic [7:0] RC_NATIVE_MASK = 8'h1f;

	// Watchdog control fields
	localparam int WD_CHANGE_BIT = 4;
	localparam int WD_ENABLE_BIT = 3;
	localparam logic [2:0] WD_PRESCALE_RST = 3'h0;
	localparam int WD_TIMED_CYCLES = 4;

	// External interrupts: sources 0..3 are limited to low level in legacy mode
	localparam int EXTINT_NUM = 8;
	localparam int EXTINT_LEGACY_LIMITED = 4;

	// Oscillator trim reset value
	localparam logic [7:0] OSC_TRIM_RST = 8'h80;

	// Serial receiver overrun depths (unread characters held)
	localparam logic [1:0] RX_DEPTH_NATIVE = 2'h2;
	localparam logic [1:0] RX_DEPTH_LEGACY = 2'h1;

	// Feature enables fanned out to the peripherals
	typedef struct packed {
		logic ext_io_en;
		logic ext_vectors_en;
		logic legacy_ram_map;
		logic usart1_en;
		logic usart_sync_en;
		logic baud_high_en;
		logic timer3_en;
		logic third_compare_en;
		logic twi_en;
		logic boot_loader_en;
		logic xmem_release_en;
		logic xmem_sector_wait_en;
	} feature_type;

	// Pin control for ports C, F and G
	typedef struct packed {
		logic [7:0] portc_oe;
		logic [7:0] portf_oe;
		logic [4:0] portg_oe;
		logic portg_gpio_en;
	} pin_ctrl_type;

endpackage : compat_pkg

// ==== mode_latch.sv ====
// Samples the compatibility fuse while reset is held and keeps the mode until the next reset
`timescale 1ns/1ps
module mode_latch
	import compat_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic legacy_compat_fuse,
	output logic compat_mode
);

	// Fuse is static hardware, but it still passes the synchroniser stages
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;

	always_ff @(posedge mclk) begin
		sync1_r <= legacy_compat_fuse;
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end

	// Capture only during reset, once the last two stages agree; frozen otherwise
	always_ff @(posedge mclk) begin
		if (sys_rst && (sync2_r == sync3_r)) begin
			compat_mode <= sync3_r;
		end
	end

endmodule : mode_latch

// ==== legacy_compat_mode_control.sv ====
// Top of the legacy compatibility mode controller with its AHB-Lite register slave
//
// Behaviour
// - Added peripheral I/O sits at 0x60..0xFF, reachable by load/store only.
// - Legacy mode only when the compatibility fuse is programmed, else native.
// - Legacy mode disables the extended window and uses the old RAM layout.
// - Legacy mode removes the extended interrupt vectors.
// - Legacy mode: one serial port, asynchronous only, low eight divisor bits.
// - Legacy mode: one 16-bit timer with two compare registers.
// - Legacy mode: two-wire interface unavailable.
// - Legacy mode: port G carries alternate functions only.
// - Legacy mode: port F is digital input only besides analog input.
// - Legacy mode: no boot-loader self-programming.
// - Legacy mode: oscillator trim writes are ignored.
// - Legacy mode: memory interface keeps all address pins, uniform wait states.
// - Legacy mode: reset cause holds only external and power-on flags.
// - Legacy mode: watchdog timeout changes need no timed sequence.
// - Legacy mode: four of eight external interrupts are low-level only.
// - Legacy mode: port C is output only.
// - Legacy mode: serial receiver has no FIFO, overrun comes earlier.
`timescale 1ns/1ps
module legacy_compat_mode_control
	import compat_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic legacy_compat_fuse,
	input wire logic por_event,
	input wire logic ext_reset_event,
	input wire logic bod_event,
	input wire logic wdt_event,
	input wire logic jtag_event,
	input wire logic [15:0] data_addr,
	input wire logic data_io_insn,
	input wire logic data_req,
	input wire logic [7:0] portc_dir_req,
	input wire logic [7:0] portf_dir_req,
	input wire logic [4:0] portg_dir_req,
	input wire logic [1:0] rx_unread,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hsel,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic compat_mode,
	output logic ext_io_hit,
	output logic ext_io_blocked,
	output feature_type features,
	output pin_ctrl_type pins,
	output logic rx_overrun,
	output logic [7:0] osc_trim,
	output logic [2:0] wdt_prescale,
	output logic wdt_enable,
	output logic [15:0] extint_sense,
	output logic [7:0] xmem_ctrl
);

	////////////////////////////////////////////////////////////////////////////
	// Mode capture

	mode_latch u_mode_latch (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.legacy_compat_fuse(legacy_compat_fuse),
		.compat_mode(compat_mode)
	);

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks on the shared constants this logic is sized for

	if (WD_TIMED_CYCLES < 1 || WD_TIMED_CYCLES > 7) begin : g_bad_wd_window
		$error("watchdog change window does not fit its 3-bit counter");
	end
	if (EXTINT_LEGACY_LIMITED > EXTINT_NUM || 2 * EXTINT_NUM != 16) begin : g_bad_extint
		$error("external interrupt counts do not match the 16-bit sense field");
	end
	// Legacy overrun must come earlier than native, since the legacy receiver has no FIFO
	if (RX_DEPTH_LEGACY >= RX_DEPTH_NATIVE) begin : g_bad_rx_depth
		$error("legacy receive depth must be below the native depth");
	end
	if (RC_LEGACY_MASK != ((8'h01 << RC_POR_BIT) | (8'h01 << RC_EXT_BIT))) begin : g_bad_cause_mask
		$error("legacy reset cause mask must hold only the power-on and external flags");
	end

	////////////////////////////////////////////////////////////////////////////
	// Feature gating

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			features <= '0;
		end else begin
			features.ext_io_en <= !compat_mode;
			features.legacy_ram_map <= compat_mode;
			features.ext_vectors_en <= !compat_mode;
			features.usart1_en <= !compat_mode;
			features.usart_sync_en <= !compat_mode;
			features.baud_high_en <= !compat_mode;
			features.timer3_en <= !compat_mode;
			features.third_compare_en <= !compat_mode;
			features.twi_en <= !compat_mode;
			features.boot_loader_en <= !compat_mode;
			features.xmem_release_en <= !compat_mode;
			features.xmem_sector_wait_en <= !compat_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Extended I/O window decode

	logic in_window;
	assign in_window = (data_addr >= EXT_IO_LO) && (data_addr <= EXT_IO_HI);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_io_hit <= 1'b0;
			ext_io_blocked <= 1'b0;
		end else begin
			// In legacy mode the window is plain RAM, so nothing in it decodes as I/O
			ext_io_hit <= data_req && in_window && !data_io_insn && !compat_mode;
			ext_io_blocked <= data_req && in_window && data_io_insn && !compat_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin direction control

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pins <= '0;
		end else if (compat_mode) begin
			pins.portc_oe <= 8'hff;
			pins.portf_oe <= 8'h00;
			pins.portg_oe <= 5'h00;
			pins.portg_gpio_en <= 1'b0;
		end else begin
			pins.portc_oe <= portc_dir_req;
			pins.portf_oe <= portf_dir_req;
			pins.portg_oe <= portg_dir_req;
			pins.portg_gpio_en <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial receive overrun

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_overrun <= 1'b0;
		end else begin
			// Without the FIFO one held character is the whole buffer
			rx_overrun <= rx_unread > (compat_mode ? RX_DEPTH_LEGACY : RX_DEPTH_NATIVE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: address phase capture

	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] addr_r;
	logic addr_ok;
	logic xfer_ok;

	assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
	assign xfer_ok = hsel && hready && htrans[1];
	// In-range reads take one wait state so that hrdata can come straight from a flip-flop
	assign hreadyout = !rd_pend_r;
	assign hresp = 1'b0;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= xfer_ok && hwrite && addr_ok && (hsize == 3'h2);
			// Out-of-range reads are not pending: they finish at once and read as zero
			rd_pend_r <= xfer_ok && !hwrite && addr_ok;
		end
	end

	// Address kept only on an accepted transfer, so a stalled bus cannot disturb the decode
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addr_r <= 8'h00;
		end else if (xfer_ok) begin
			addr_r <= haddr[7:0];
		end
	end

	logic [7:0] wb;
	assign wb = hwdata[7:0];

	logic wr_reset_cause;
	logic wr_osc;
	logic wr_wdt;
	logic wr_extint;
	logic wr_xmem;
	assign wr_reset_cause = wr_pend_r && (addr_r == ADDR_RESET_CAUSE);
	assign wr_osc = wr_pend_r && (addr_r == ADDR_OSC_TRIM);
	assign wr_wdt = wr_pend_r && (addr_r == ADDR_WDT_CTRL);
	assign wr_extint = wr_pend_r && (addr_r == ADDR_EXTINT_SENSE);
	assign wr_xmem = wr_pend_r && (addr_r == ADDR_XMEM_CTRL);

	////////////////////////////////////////////////////////////////////////////
	// Reset cause flags: write one to clear, a new event wins over the clear

	logic [7:0] reset_cause_status_reg_r;
	logic [7:0] cause_evt;
	logic [7:0] cause_mask;

	assign cause_evt = {3'h0, jtag_event, wdt_event, bod_event, ext_reset_event, por_event};
	assign cause_mask = compat_mode ? RC_LEGACY_MASK : RC_NATIVE_MASK;

	// Flags survive sys_rst on purpose: they report why the reset happened
	always_ff @(posedge mclk) begin
		if (por_event) begin
			reset_cause_status_reg_r <= 8'h01 << RC_POR_BIT;
		end else begin
			reset_cause_status_reg_r <= ((reset_cause_status_reg_r & ~(wr_reset_cause ? wb : 8'h00))
				| cause_evt) & cause_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Oscillator trim

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			osc_trim <= OSC_TRIM_RST;
		end else if (wr_osc && !compat_mode) begin
			osc_trim <= wb;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog control with timed change window

	logic [2:0] wd_win_r;
	logic wd_open;
	assign wd_open = (wd_win_r != 3'h0);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wd_win_r <= 3'h0;
		end else if (wr_wdt && wb[WD_CHANGE_BIT] && wb[WD_ENABLE_BIT]) begin
			wd_win_r <= 3'(WD_TIMED_CYCLES);
		end else if (wd_open) begin
			wd_win_r <= wd_win_r - 3'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wdt_prescale <= WD_PRESCALE_RST;
			wdt_enable <= 1'b0;
		end else if (wr_wdt) begin
			if (compat_mode || wd_open) begin
				wdt_prescale <= wb[2:0];
				wdt_enable <= wb[WD_ENABLE_BIT];
			end else if (wb[WD_ENABLE_BIT]) begin
				// Enabling is always allowed; only change/disable needs the window
				wdt_enable <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// External interrupt sense, two bits per source

	genvar gi;
	generate
		for (gi = 0; gi < EXTINT_NUM; gi++) begin : g_sense
			always_ff @(posedge mclk) begin
				if (sys_rst) begin
					extint_sense[2*gi +: 2] <= 2'h0;
				end else if (compat_mode && (gi < EXTINT_LEGACY_LIMITED)) begin
					extint_sense[2*gi +: 2] <= 2'h0;
				end else if (wr_extint) begin
					extint_sense[2*gi +: 2] <= hwdata[2*gi +: 2];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// External memory control: bits 2..0 release mask, bit 3 sector wait enable

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			xmem_ctrl <= 8'h00;
		end else if (compat_mode) begin
			xmem_ctrl <= 8'h00;
		end else if (wr_xmem) begin
			xmem_ctrl <= wb;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	logic [31:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 32'h00000000;
		if (addr_r == ADDR_MODE_STATUS) begin
			rdata_nxt[MS_COMPAT_BIT] = compat_mode;
			rdata_nxt[MS_VIOL_BIT] = ext_io_blocked;
		end else if (addr_r == ADDR_DATA_ACCESS) begin
			rdata_nxt[DA_ADDR_LSB +: 16] = data_addr;
			rdata_nxt[DA_IO_INSN_BIT] = data_io_insn;
		end else if (addr_r == ADDR_RESET_CAUSE) begin
			rdata_nxt[7:0] = reset_cause_status_reg_r;
		end else if (addr_r == ADDR_OSC_TRIM) begin
			rdata_nxt[7:0] = osc_trim;
		end else if (addr_r == ADDR_WDT_CTRL) begin
			rdata_nxt[3:0] = {wdt_enable, wdt_prescale};
		end else if (addr_r == ADDR_EXTINT_SENSE) begin
			rdata_nxt[15:0] = extint_sense;
		end else if (addr_r == ADDR_XMEM_CTRL) begin
			rdata_nxt[7:0] = xmem_ctrl;
		end else if (addr_r == ADDR_PORT_DIR) begin
			rdata_nxt[20:0] = {pins.portg_oe, pins.portf_oe, pins.portc_oe};
		end
	end

	// Read data stands for the single ready cycle that ends the read, and is zero otherwise
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend_r) begin
			hrdata <= rdata_nxt;
		end else begin
			hrdata <= 32'h00000000;
		end
	end

endmodule : legacy_compat_mode_control

// ==== compat_ctl_props.sv ====
// Port-level assertions for the compatibility mode controller
`timescale 1ns/1ps
module compat_ctl_props
	import compat_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [15:0] data_addr,
	input wire logic data_io_insn,
	input wire logic data_req,
	input wire logic [7:0] portc_dir_req,
	input wire logic [7:0] portf_dir_req,
	input wire logic [4:0] portg_dir_req,
	input wire logic [1:0] rx_unread,
	input wire logic compat_mode,
	input wire logic ext_io_hit,
	input wire logic ext_io_blocked,
	input wire feature_type features,
	input wire pin_ctrl_type pins,
	input wire logic rx_overrun,
	input wire logic [7:0] osc_trim,
	input wire logic [15:0] extint_sense,
	input wire logic [7:0] xmem_ctrl
);
	logic win;
	assign win = data_req && data_addr >= EXT_IO_LO && data_addr <= EXT_IO_HI;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	AST_HIT: assert property (win && !data_io_insn && !compat_mode |=> ext_io_hit)
		else $error("window hit missing");
	AST_IO_BLOCK: assert property (win && data_io_insn && !compat_mode |=> ext_io_blocked && !ext_io_hit)
		else $error("io instruction reached window");
	AST_LEGACY_OFF: assert property (compat_mode |=> !ext_io_hit && !ext_io_blocked)
		else $error("window active in legacy mode");
	// Antecedents skip the edge that lowers reset, where registered outputs still hold reset values
	AST_FEAT_LEG: assert property (!sys_rst && compat_mode |=> features == 12'h200)
		else $error("legacy feature set wrong");
	AST_FEAT_NAT: assert property (!sys_rst && !compat_mode |=> features == 12'hdff)
		else $error("native feature set wrong");
	AST_PINS_LEG: assert property (!sys_rst && compat_mode |=> pins == {8'hff, 8'h00, 5'h00, 1'b0})
		else $error("legacy pin control wrong");
	AST_PINS_NAT: assert property (!sys_rst && !compat_mode |=>
		pins == {$past(portc_dir_req), $past(portf_dir_req), $past(portg_dir_req), 1'b1})
		else $error("native pins not following requests");
	AST_OVERRUN: assert property (!sys_rst |=>
		rx_overrun == ($past(rx_unread) > ($past(compat_mode) ? 2'h1 : 2'h2)))
		else $error("overrun depth wrong");
	AST_TRIM: assert property (compat_mode |=> $stable(osc_trim))
		else $error("trim moved in legacy mode");
	AST_LIMITS: assert property (compat_mode |-> xmem_ctrl == 8'h00 && extint_sense[7:0] == 8'h00)
		else $error("legacy limits not applied");
	AST_MODE_HOLD: assert property (1'b1 |=> $stable(compat_mode))
		else $error("mode changed outside reset");
endmodule : compat_ctl_props

bind legacy_compat_mode_control compat_ctl_props chk_u (.mclk, .sys_rst, .data_addr, .data_io_insn, .data_req,
	.portc_dir_req, .portf_dir_req, .portg_dir_req, .rx_unread, .compat_mode, .ext_io_hit, .ext_io_blocked,
	.features, .pins, .rx_overrun, .osc_trim, .extint_sense, .xmem_ctrl);

// ==== testbench.sv ====
// Self-checking bench for the compatibility mode controller
`timescale 1ns/1ps
module testbench;
	import compat_pkg::*;
	typedef struct packed {logic f; logic [15:0] a; logic io; logic [1:0] rx; logic hit; logic blk; logic ovr;} row_type;
	logic mclk = 0, sys_rst = 1, legacy_compat_fuse = 0, data_io_insn = 0, data_req = 0, hwrite = 0, hsel = 0;
	logic por_event = 0, ext_reset_event = 0, bod_event = 0, wdt_event = 0, jtag_event = 0;
	logic [15:0] data_addr = 0;
	logic [7:0] portc_dir_req = 0, portf_dir_req = 0, osc_trim, xmem_ctrl;
	logic [4:0] portg_dir_req = 0;
	logic [1:0] rx_unread = 0, htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [2:0] hsize = 0, wdt_prescale;
	logic hreadyout, hresp, compat_mode, ext_io_hit, ext_io_blocked, rx_overrun, wdt_enable;
	logic [15:0] extint_sense;
	feature_type features;
	pin_ctrl_type pins;
	int error_cnt = 0, checked = 0;
	row_type rows[8] = '{{1'b0, 16'h0060, 1'b0, 2'h2, 3'b100}, {1'b0, 16'h00ff, 1'b0, 2'h3, 3'b101},
		{1'b0, 16'h005f, 1'b0, 2'h1, 3'b000}, {1'b0, 16'h0100, 1'b0, 2'h0, 3'b000},
		{1'b0, 16'h0080, 1'b1, 2'h2, 3'b010}, {1'b1, 16'h0080, 1'b0, 2'h2, 3'b001},
		{1'b1, 16'h00ff, 1'b1, 2'h1, 3'b000}, {1'b1, 16'h0060, 1'b0, 2'h0, 3'b000}};
	always #2.5 mclk = ~mclk;
	legacy_compat_mode_control dut_u (.mclk(mclk), .sys_rst(sys_rst), .legacy_compat_fuse(legacy_compat_fuse),
		.por_event(por_event), .ext_reset_event(ext_reset_event), .bod_event(bod_event), .wdt_event(wdt_event),
		.jtag_event(jtag_event), .data_addr(data_addr), .data_io_insn(data_io_insn), .data_req(data_req),
		.portc_dir_req(portc_dir_req), .portf_dir_req(portf_dir_req), .portg_dir_req(portg_dir_req),
		.rx_unread(rx_unread), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hsel(hsel), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.compat_mode(compat_mode), .ext_io_hit(ext_io_hit), .ext_io_blocked(ext_io_blocked), .features(features),
		.pins(pins), .rx_overrun(rx_overrun), .osc_trim(osc_trim), .wdt_prescale(wdt_prescale),
		.wdt_enable(wdt_enable), .extint_sense(extint_sense), .xmem_ctrl(xmem_ctrl));
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	task test_done;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// Entered at a rising edge; one slave, so its hreadyout is the bus ready
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'h2;
		hsel <= 1'b1;
		htrans <= 2'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, 32'h0, "response");
	endtask : ahb
	task rst(input logic f);
		sys_rst <= 1'b1;
		legacy_compat_fuse <= f;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk(compat_mode, f, "mode");
		chk(features, f ? 12'h200 : 12'hdff, "features");
		@(posedge mclk);
	endtask : rst
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge mclk);
		error_cnt++;
		test_done();
	end
	initial begin
		@(posedge mclk);
		foreach (rows[i]) begin
			if (i == 0 || rows[i].f !== legacy_compat_fuse) rst(rows[i].f);
			data_addr <= rows[i].a;
			data_io_insn <= rows[i].io;
			data_req <= 1'b1;
			rx_unread <= rows[i].rx;
			portc_dir_req <= rows[i].a[7:0];
			portf_dir_req <= ~rows[i].a[7:0];
			portg_dir_req <= rows[i].a[4:0];
			@(posedge mclk);
			data_req <= 1'b0;
			#1;
			chk({ext_io_hit, ext_io_blocked, rx_overrun}, {rows[i].hit, rows[i].blk, rows[i].ovr}, "decode");
			chk(pins, rows[i].f ? {8'hff, 8'h00, 5'h00, 1'b0} :
				{rows[i].a[7:0], ~rows[i].a[7:0], rows[i].a[4:0], 1'b1}, "pins");
			@(posedge mclk);
		end
		$display("decode table done");
		for (int m = 0; m < 2; m++) begin
			rst(m[0]);
			por_event <= 1'b1;
			@(posedge mclk);
			por_event <= 1'b0;
			{ext_reset_event, bod_event, wdt_event, jtag_event} <= 4'hf;
			@(posedge mclk);
			{ext_reset_event, bod_event, wdt_event, jtag_event} <= 4'h0;
			ahb(1'b0, ADDR_RESET_CAUSE, 32'h0);
			chk(rd, m ? 32'h03 : 32'h1f, "reset cause");
			ahb(1'b1, ADDR_RESET_CAUSE, m ? 32'h03 : 32'h1f);
			ahb(1'b1, ADDR_WDT_CTRL, 32'h0d);
			ahb(1'b0, ADDR_RESET_CAUSE, 32'h0);
			chk(rd, 32'h0, "cause clear");
			chk({wdt_enable, wdt_prescale}, m ? 4'hd : 4'h8, "untimed watchdog write");
			ahb(1'b1, ADDR_WDT_CTRL, 32'h18);
			ahb(1'b1, ADDR_WDT_CTRL, 32'h0e);
			ahb(1'b0, 8'h40, 32'h0);
			chk(rd, 32'h0, "unmapped read");
			chk({wdt_enable, wdt_prescale}, 4'he, "timed watchdog write");
			ahb(1'b1, ADDR_OSC_TRIM, 32'h5a);
			ahb(1'b1, ADDR_EXTINT_SENSE, 32'hffff);
			ahb(1'b1, ADDR_XMEM_CTRL, 32'hff);
			ahb(1'b0, ADDR_MODE_STATUS, 32'h0);
			chk(rd, m, "status");
			chk(osc_trim, m ? 8'h80 : 8'h5a, "trim");
			chk(extint_sense, m ? 16'hff00 : 16'hffff, "extint sense");
			chk(xmem_ctrl, m ? 8'h00 : 8'hff, "xmem");
			ahb(1'b0, ADDR_DATA_ACCESS, 32'h0);
			chk(rd, 32'h00000060, "data probe");
			ahb(1'b0, ADDR_PORT_DIR, 32'h0);
			chk(rd, m ? 32'h000000ff : 32'h00009f60, "pin readback");
			legacy_compat_fuse <= ~m[0];
			repeat (6) @(posedge mclk);
			chk(compat_mode, m, "mode held");
			$display("mode %0d tests done", m);
		end
		test_done();
	end
endmodule : testbench
